// File: verilog/cswc_pkg.sv
package cswc_pkg;

  localparam int unsigned DW       = 32;
  localparam int unsigned AW       = 4;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned FLD_W    = 4;
  localparam int unsigned NUM_CS   = 4;
  localparam int unsigned CS_W     = 2;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_WCTL = 4'h0;
  localparam logic [AW-1:0] OFS_DSW  = 4'h4;
  localparam logic [AW-1:0] OFS_STAT = 4'h8;

  // Field positions inside the wait control word
  localparam int unsigned CS3_LSB  = 12;
  localparam int unsigned CS3_MSB  = 15;
  localparam int unsigned CS2_LSB  = 8;
  localparam int unsigned CS2_MSB  = 11;
  localparam int unsigned CS1_LSB  = 4;
  localparam int unsigned CS1_MSB  = 7;
  localparam int unsigned CS0_LSB  = 0;
  localparam int unsigned CS0_MSB  = 3;

  // Status word layout
  localparam int unsigned ST_CNT_LSB  = 0;
  localparam int unsigned ST_EXTW_BIT = 4;
  localparam int unsigned ST_DMA_BIT  = 5;
  localparam int unsigned ST_CS_LSB   = 6;
  localparam int unsigned ST_BUSY_BIT = 8;

  // Reset values and wait count constants
  localparam logic [REG_W-1:0] WCTL_RST = 16'hffff;
  localparam logic [FLD_W-1:0] DSW_RST  = 4'hf;
  localparam logic [FLD_W-1:0] WAIT_NONE = 4'h0;
  localparam logic [FLD_W-1:0] WAIT_ONE  = 4'h1;

  // Access sequencer states, Gray along idle-setup-wait-last
  typedef enum logic [2:0] {
    CSWC_IDLE  = 3'h0,
    CSWC_SETUP = 3'h1,
    CSWC_WAIT  = 3'h3,
    CSWC_LAST  = 3'h2,
    CSWC_EXTW  = 3'h6
  } cswc_state_e;

endpackage : cswc_pkg

// File: verilog/cswc_sync.sv
`timescale 1ns/100ps
module cswc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Three stages; level follows once the last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule : cswc_sync

// File: verilog/cswc_top.sv
// Behaviour
// R1: Space 3 wait count comes from control bits 15 to 12.
// R2: Space 2 wait count comes from control bits 11 to 8.
// R3: Space 1 wait count comes from control bits 7 to 4.
// R4: Space 0 wait count comes from control bits 3 to 0.
// R5: Field zero inserts no waits and ignores the external wait input.
// R6: Field n from 1 to 15 inserts n waits and honours external wait.
// R7: Reset loads 1111 into every space wait field.
// R8: Single-address DMA accesses use their own separate wait setting.
// R9: External wait held after programmed waits extends the access until released.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module cswc_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [cswc_pkg::AW-1:0]      wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [cswc_pkg::DW-1:0]      wb_dat_i,
  output logic      [cswc_pkg::DW-1:0]      wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         acc_req_i,
  input  wire logic [cswc_pkg::CS_W-1:0]    acc_cs_i,
  input  wire logic                         acc_dma_i,
  output logic                              acc_busy_o,
  output logic                              acc_done_o,
  output logic [cswc_pkg::NUM_CS-1:0]       cs_n_o,
  input  wire logic                         ext_wait_n_i
);
  import cswc_pkg::*;

  cswc_state_e              state_q;
  logic [REG_W-1:0]         wctl_q;
  logic [FLD_W-1:0]         dsw_q;
  logic [CS_W-1:0]          cs_q;
  logic                     dma_q;
  logic                     ext_en_q;
  logic [FLD_W-1:0]         cnt_q;
  logic [FLD_W-1:0]         ld_wait_q;
  logic                     wait_lvl_n;
  logic                     ext_wait;
  logic                     wb_hit;
  logic [FLD_W-1:0]         req_wait;
  logic [FLD_W-1:0]         wcyc_q;

  // Wait field of one space
  function automatic logic [FLD_W-1:0] space_field(input logic [REG_W-1:0] ctl,
                                                   input logic [CS_W-1:0]  cs);
    logic [FLD_W-1:0] f;
    f = WAIT_NONE;
    case (cs)
      2'h3:    f = ctl[CS3_MSB:CS3_LSB]; // R1
      2'h2:    f = ctl[CS2_MSB:CS2_LSB]; // R2
      2'h1:    f = ctl[CS1_MSB:CS1_LSB]; // R3
      default: f = ctl[CS0_MSB:CS0_LSB]; // R4
    endcase
    return f;
  endfunction : space_field

  // Byte-lane merge of a write into a register
  function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old,
                                                  input logic [REG_W-1:0] wdat,
                                                  input logic [1:0]       sel);
    logic [REG_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction : lane_merge

  cswc_sync u_wait_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (ext_wait_n_i),
    .level_o (wait_lvl_n)
  );

  assign ext_wait = ~wait_lvl_n;
  assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign req_wait = acc_dma_i ? dsw_q : space_field(wctl_q, acc_cs_i); // R8

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
    end
  end

  // Wait control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wctl_q <= WCTL_RST; // R7
    end else if (ce_i && wb_hit && wb_we_i && wb_adr_i == OFS_WCTL) begin
      wctl_q <= lane_merge(wctl_q, wb_dat_i[REG_W-1:0], wb_sel_i[1:0]);
    end
  end

  // Single-address DMA wait register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsw_q <= DSW_RST;
    end else if (ce_i && wb_hit && wb_we_i && wb_adr_i == OFS_DSW && wb_sel_i[0]) begin
      dsw_q <= wb_dat_i[FLD_W-1:0]; // R8
    end
  end

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          OFS_WCTL: wb_dat_o[REG_W-1:0] <= wctl_q;
          OFS_DSW:  wb_dat_o[FLD_W-1:0] <= dsw_q;
          OFS_STAT: begin
            wb_dat_o[ST_CNT_LSB +: FLD_W] <= cnt_q;
            wb_dat_o[ST_EXTW_BIT]         <= ext_wait;
            wb_dat_o[ST_DMA_BIT]          <= dma_q;
            wb_dat_o[ST_CS_LSB +: CS_W]   <= cs_q;
            wb_dat_o[ST_BUSY_BIT]         <= acc_busy_o;
          end
          default:  wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Access sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= CSWC_IDLE;
      cs_q      <= '0;
      dma_q     <= 1'b0;
      ext_en_q  <= 1'b0;
      cnt_q     <= WAIT_NONE;
      ld_wait_q <= WAIT_NONE;
    end else if (ce_i) begin
      case (state_q)
        CSWC_IDLE: begin
          if (acc_req_i) begin
            state_q   <= CSWC_SETUP;
            cs_q      <= acc_cs_i;
            dma_q     <= acc_dma_i;
            cnt_q     <= req_wait;
            ld_wait_q <= req_wait;
            ext_en_q  <= (req_wait != WAIT_NONE); // R5 R6
          end
        end
        CSWC_SETUP: begin
          if (cnt_q == WAIT_NONE) begin
            state_q <= CSWC_LAST; // R5
          end else begin
            state_q <= CSWC_WAIT; // R6
          end
        end
        CSWC_WAIT: begin
          cnt_q <= cnt_q - WAIT_ONE;
          if (cnt_q == WAIT_ONE) begin
            state_q <= (ext_en_q && ext_wait) ? CSWC_EXTW : CSWC_LAST; // R6 R9
          end
        end
        CSWC_EXTW: begin
          if (!ext_wait) begin
            state_q <= CSWC_LAST; // R9
          end
        end
        CSWC_LAST: begin
          state_q <= CSWC_IDLE;
        end
        default: begin
          state_q <= CSWC_IDLE;
        end
      endcase
    end
  end

  // Chip selects, busy and done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_n_o     <= '1;
      acc_busy_o <= 1'b0;
      acc_done_o <= 1'b0;
    end else if (ce_i) begin
      acc_done_o <= (state_q == CSWC_LAST);
      if (state_q == CSWC_IDLE && acc_req_i) begin
        cs_n_o     <= ~(NUM_CS'(1) << acc_cs_i);
        acc_busy_o <= 1'b1;
      end else if (state_q == CSWC_LAST) begin
        cs_n_o     <= '1;
        acc_busy_o <= 1'b0;
      end
    end
  end

  // Helper: counts cycles spent in programmed wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcyc_q <= '0;
    end else if (ce_i) begin
      if (state_q == CSWC_SETUP) begin
        wcyc_q <= '0;
      end else if (state_q == CSWC_WAIT) begin
        wcyc_q <= wcyc_q + WAIT_ONE;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  AST_CS3_FIELD: assert property ( // R1
    (state_q == CSWC_SETUP && cs_q == 2'h3 && !dma_q) |-> ld_wait_q == wctl_q[CS3_MSB:CS3_LSB])
    else $error("space 3 wait not from its field");
  AST_CS2_FIELD: assert property ( // R2
    (state_q == CSWC_SETUP && cs_q == 2'h2 && !dma_q) |-> ld_wait_q == wctl_q[CS2_MSB:CS2_LSB])
    else $error("space 2 wait not from its field");
  AST_CS1_FIELD: assert property ( // R3
    (state_q == CSWC_SETUP && cs_q == 2'h1 && !dma_q) |-> ld_wait_q == wctl_q[CS1_MSB:CS1_LSB])
    else $error("space 1 wait not from its field");
  AST_CS0_FIELD: assert property ( // R4
    (state_q == CSWC_SETUP && cs_q == 2'h0 && !dma_q) |-> ld_wait_q == wctl_q[CS0_MSB:CS0_LSB])
    else $error("space 0 wait not from its field");
  AST_ZERO_NOWAIT: assert property ( // R5
    (state_q == CSWC_SETUP && ld_wait_q == WAIT_NONE) |=> state_q == CSWC_LAST ##1 acc_done_o)
    else $error("zero wait access did not finish directly");
  AST_ZERO_NOEXT: assert property ( // R5
    (state_q == CSWC_EXTW) |-> ext_en_q && ld_wait_q != WAIT_NONE)
    else $error("external wait honoured with zero field");
  AST_N_WAITS: assert property ( // R6
    ($past(state_q) == CSWC_WAIT && state_q != CSWC_WAIT) |-> wcyc_q == ld_wait_q)
    else $error("programmed wait count not met");
  AST_EXT_HOLD: assert property ( // R9
    (state_q == CSWC_EXTW && ext_wait) |=> state_q == CSWC_EXTW && !acc_done_o)
    else $error("access ended while external wait held");
  AST_EXT_RELEASE: assert property ( // R9
    (state_q == CSWC_EXTW && !ext_wait) |=> state_q == CSWC_LAST)
    else $error("access not resumed after wait release");
  AST_DMA_WAIT: assert property ( // R8
    (state_q == CSWC_SETUP && dma_q) |-> ld_wait_q == dsw_q)
    else $error("dma access not using its own wait");
  AST_RESET_FIELDS: assert property (@(posedge clk_i) disable iff (1'b0) // R7
    rst_i |=> wctl_q == WCTL_RST && dsw_q == DSW_RST)
    else $error("reset did not load maximum waits");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_DAT_IDLE_ZERO: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  AST_WCTL_HOLD: assert property ( // R7
    !(wb_hit && wb_we_i && wb_adr_i == OFS_WCTL) |=> $stable(wctl_q))
    else $error("wait control changed without a write");

  // Access shape and chip select checks
  AST_TAKE_REQ: assert property (
    (state_q == CSWC_IDLE && acc_req_i) |=> state_q == CSWC_SETUP && acc_busy_o)
    else $error("idle request not taken");
  AST_EXT_ENABLE: assert property ( // R5
    (state_q == CSWC_SETUP) |-> ext_en_q == (ld_wait_q != WAIT_NONE))
    else $error("external wait enable does not follow field");
  AST_WAIT_STEP: assert property ( // R6
    (state_q == CSWC_WAIT && cnt_q != WAIT_ONE) |=>
      state_q == CSWC_WAIT && cnt_q == $past(cnt_q) - WAIT_ONE)
    else $error("wait count did not step down");
  AST_WAIT_END: assert property ( // R6
    (state_q == CSWC_WAIT && cnt_q == WAIT_ONE && !ext_wait) |=> state_q == CSWC_LAST)
    else $error("programmed wait not ended on last count");
  AST_EXT_ENTER: assert property ( // R9
    (state_q == CSWC_WAIT && cnt_q == WAIT_ONE && ext_wait) |=> state_q == CSWC_EXTW)
    else $error("held external wait not honoured");
  AST_CS_ONE_LOW: assert property (
    acc_busy_o |-> $onehot(~cs_n_o) && !cs_n_o[cs_q])
    else $error("chip select not the requested space");
  AST_CS_IDLE: assert property (
    !acc_busy_o |-> cs_n_o == '1)
    else $error("chip select low while not busy");
  AST_DONE_PULSE: assert property (
    acc_done_o |=> !acc_done_o)
    else $error("done held longer than one cycle");
  AST_DONE_IDLE: assert property (
    acc_done_o |-> !acc_busy_o && state_q == CSWC_IDLE)
    else $error("done while access still running");
  AST_DMA_CS_KEEP: assert property ( // R8
    (state_q == CSWC_SETUP && dma_q) |-> !cs_n_o[cs_q])
    else $error("dma access without its chip select");

  COV_ZERO_WAIT: cover property (state_q == CSWC_SETUP && ld_wait_q == WAIT_NONE);
  COV_MAX_WAIT: cover property (state_q == CSWC_SETUP && ld_wait_q == WCTL_RST[FLD_W-1:0]);
  COV_EXT_WAIT: cover property (state_q == CSWC_EXTW ##1 state_q == CSWC_LAST);
  COV_DMA: cover property (state_q == CSWC_SETUP && dma_q);

endmodule : cswc_top

// File: verification/cswc_mem_model.sv
`timescale 1ns/100ps
module cswc_mem_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] cs_n_i,
  input  wire logic [7:0] hold_i,
  output logic            wait_n_o
);
  logic [7:0] sel_cnt_q;

  // Counts cycles of the current selection
  always_ff @(posedge clk_i) begin
    if (&cs_n_i) begin
      sel_cnt_q <= 8'h00;
    end else if (sel_cnt_q != 8'hff) begin
      sel_cnt_q <= sel_cnt_q + 8'h01;
    end
  end

  // Wait low for hold_i selected cycles, pulled up when idle
  assign wait_n_o = (&cs_n_i) ? 1'b1 : (sel_cnt_q >= hold_i);
endmodule : cswc_mem_model

// File: verification/cswc_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module cswc_top_tb;
  import cswc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, adma = 1'b0, ce = 1'b1;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, e, h, seed = 32'he1980c79;
  logic [1:0]  acs = 2'h0;
  logic [7:0]  hold = 8'h00;
  logic [15:0] ctl, tab [3];
  logic [3:0]  csn;
  logic        ack, busy, done, wait_n;
  logic [31:0] eq [$], hq [$];
  int          mismatches = 0, total_checks = 0, lat = 0;

  always #4 clk_i = ~clk_i;

  cswc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .acc_req_i(req), .acc_cs_i(acs),
    .acc_dma_i(adma), .acc_busy_o(busy), .acc_done_o(done), .cs_n_o(csn),
    .ext_wait_n_i(wait_n));

  cswc_mem_model mem (.clk_i(clk_i), .cs_n_i(csn), .hold_i(hold), .wait_n_o(wait_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    eq.push_back(x); hq.push_back(x);
    wb(a, 1'b0, 32'h0, 4'hf);
  endtask : rd

  task automatic acc(input logic [1:0] c, input logic d, input int lo, input int hi);
    int n;
    eq.push_back(lo); hq.push_back(hi);
    req <= 1'b1; acs <= c; adma <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (busy !== 1'b1 && n < 50);
    req <= 1'b0;
    if (n >= 50) mismatches++;
    n = 0;
    do begin @(posedge clk_i); n++; end while (done !== 1'b1 && n < 100);
    if (n >= 100) mismatches++;
    @(posedge clk_i);
  endtask : acc

  // Scoreboard: oldest note against each read or finished access
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      e = eq.pop_front(); h = hq.pop_front();
      `CHK(lat >= e && lat <= h, 1'b1)
      `CHK(csn, 4'hf)
      lat = 0;
    end else if (busy === 1'b1) begin
      lat++;
      `CHK(csn, ~(4'h1 << acs))
    end
    if (ack === 1'b1 && we === 1'b0) begin
      e = eq.pop_front(); h = hq.pop_front();
      `CHK(rdat, e)
    end
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(OFS_WCTL, 32'h0000ffff);
    rd(OFS_DSW, 32'h0000000f);
    rd(4'hc, 32'h0);
    seed = lfsr(lfsr(seed));
    tab = '{16'h0f1e, 16'he1f0, seed[15:0]};
    foreach (tab[k]) begin
      ctl = tab[k];
      seed = lfsr(seed);
      wb(OFS_WCTL, 1'b1, {seed[31:16], ctl}, 4'h3);
      rd(OFS_WCTL, {16'h0, ctl});
      for (int c = 0; c < 4; c++) begin
        int w;
        w = ctl[c*4 +: 4];
        hold <= 8'd0;
        acc(c[1:0], 1'b0, w + 2, w + 2);
        hold <= 8'd20;
        // Waits under 4 end before the held pin has crossed the synchroniser
        if (w == 0) acc(c[1:0], 1'b0, 2, 2);
        else if (w < 4) acc(c[1:0], 1'b0, w + 2, w + 2);
        else acc(c[1:0], 1'b0, 21, 28);
      end
    end
    hold <= 8'd0;
    wb(OFS_WCTL, 1'b1, 32'h0000a5c3, 4'h2);
    rd(OFS_WCTL, {16'h0, 8'ha5, ctl[7:0]});
    wb(4'hc, 1'b1, 32'h0, 4'hf);
    wb(OFS_DSW, 1'b1, 32'h2, 4'h1);
    rd(OFS_WCTL, {16'h0, 8'ha5, ctl[7:0]});
    rd(OFS_DSW, 32'h2);
    acc(2'd2, 1'b1, 4, 4);
    // Clock enable low for three edges stretches the access by three
    fork
      acc(2'd2, 1'b1, 7, 7);
      begin
        repeat (3) @(posedge clk_i);
        ce <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce <= 1'b1;
      end
    join
    rd(OFS_STAT, 32'h000000a0);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(OFS_WCTL, 32'h0000ffff);
    acc(2'd3, 1'b0, 17, 17);
    print_verdict();
  end
endmodule : cswc_top_tb
